// ---- include/pmseq_pkg.sv ----
// shared constants and types for the power mode sequencer
package pmseq_pkg;
   typedef enum logic [1:0] {
      normal_power_mode,
      reduced_power_mode,
      low_power_mode,
      sleep_power_mode
   } pmseq_mode_e;

   typedef enum logic [1:0] {
      PMSEQ_ST_IDLE,
      PMSEQ_ST_TRANS,
      PMSEQ_ST_DONE
   } pmseq_state_e;

   // pin codes, high pin first
   localparam logic [1:0] PMSEQ_PINS_NORMAL  = 2'h1;
   localparam logic [1:0] PMSEQ_PINS_REDUCED = 2'h0;
   localparam logic [1:0] PMSEQ_PINS_LOWPWR  = 2'h2;
   localparam logic [1:0] PMSEQ_PINS_SLEEP   = 2'h3;

   // register indices on the serial register port
   localparam logic [3:0] PMSEQ_REG_STATUS_B   = 4'h0;
   localparam logic [3:0] PMSEQ_REG_IRQ_MASK   = 4'h1;
   localparam logic [3:0] PMSEQ_REG_CTRL       = 4'h2;
   localparam logic [3:0] PMSEQ_REG_LP_THRESH  = 4'h3;
   localparam logic [3:0] PMSEQ_REG_RET_CONFIG = 4'h4;
   localparam logic [3:0] PMSEQ_REG_MAV_A      = 4'h5;
   localparam logic [3:0] PMSEQ_REG_MAV_B      = 4'h6;
   localparam logic [3:0] PMSEQ_REG_MAV_C      = 4'h7;
   localparam logic [3:0] PMSEQ_REG_RMS_I      = 4'h8;
   localparam logic [3:0] PMSEQ_REG_RMS_V      = 4'h9;
   localparam logic [3:0] PMSEQ_REG_MODE       = 4'hA;

   localparam int          PMSEQ_DONE_BIT     = 15;
   localparam logic [31:0] PMSEQ_MASK_RST     = 32'h0000_0000;
   localparam logic [31:0] PMSEQ_CTRL_RST     = 32'h0000_0000;
   localparam logic [7:0]  PMSEQ_LPTH_RST     = 8'h07;
   localparam logic [31:0] PMSEQ_RETCFG_RST   = 32'h0000_0000;

   localparam int PMSEQ_MAV_W = 20;
   localparam int PMSEQ_RMS_W = 24;
   // mav averaging window, log2 of sample count
   localparam int PMSEQ_MAV_SHIFT = 4;

   // transition period
   localparam int PMSEQ_CLK_MHZ    = 125;
   localparam int PMSEQ_TRANS_NS   = 1000;
   localparam int PMSEQ_TRANS_CYC  = (PMSEQ_TRANS_NS * PMSEQ_CLK_MHZ + 999) / 1000;
   localparam int PMSEQ_CNT_W      = 12;
   // host register access timeout
   localparam logic [3:0] PMSEQ_HOST_WAIT = 4'h2;
endpackage : pmseq_pkg

// ---- include/pmseq_if.sv ----
// pins and serial register port joining controller and metering device
`timescale 1ns/100ps
interface pmseq_if;
   logic        mode_select_high_pin;
   logic        mode_select_low_pin;
   logic        mode_high_oe;
   logic        mode_low_oe;
   logic        event_irq_b_n;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        reg_rvalid;
   // internal pull-ups: undriven pins read high
   logic        mode_high_level;
   logic        mode_low_level;
   assign mode_high_level = mode_high_oe ? mode_select_high_pin : 1'b1;
   assign mode_low_level  = mode_low_oe  ? mode_select_low_pin  : 1'b1;

   modport dev (
      input  mode_high_level, mode_low_level, reg_addr, reg_wdata, reg_wr, reg_rd,
      output event_irq_b_n, reg_rdata, reg_rvalid
   );
   modport ctl (
      output mode_select_high_pin, mode_select_low_pin, mode_high_oe, mode_low_oe,
      output reg_addr, reg_wdata, reg_wr, reg_rd,
      input  event_irq_b_n, reg_rdata, reg_rvalid
   );
endinterface : pmseq_if

// ---- core/pmseq_device.sv ----
// metering device end: mode decode, register defaulting, done flag, mav
`timescale 1ns/100ps
module pmseq_device
   import pmseq_pkg::*;
#(
   parameter bit FULL_FEATURE = 1'b1
)
(
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // link to controller
   pmseq_if.dev                        link,
   // measurement samples and results
   input  wire logic [PMSEQ_MAV_W-1:0] phase_sample_a,
   input  wire logic [PMSEQ_MAV_W-1:0] phase_sample_b,
   input  wire logic [PMSEQ_MAV_W-1:0] phase_sample_c,
   input  wire logic                   sample_strobe,
   input  wire logic [PMSEQ_RMS_W-1:0] rms_current_in,
   input  wire logic [PMSEQ_RMS_W-1:0] rms_voltage_in,
   // mode seen by the rest of the chip
   output pmseq_mode_e                 power_mode,
   output logic [31:0]                 ctrl_out
);
   // two-stage synchroniser, first stage feeds only the second
   logic [1:0] sync1_r, sync2_r;
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_r <= PMSEQ_PINS_SLEEP;
         sync2_r <= PMSEQ_PINS_SLEEP;
      end
      else
      begin
         sync1_r <= {link.mode_high_level, link.mode_low_level};
         sync2_r <= sync1_r;
      end
   end

   pmseq_mode_e decoded;
   always_comb
   begin
      case (sync2_r)
         PMSEQ_PINS_NORMAL:  decoded = normal_power_mode;
         PMSEQ_PINS_REDUCED: decoded = FULL_FEATURE ? reduced_power_mode : sleep_power_mode;
         PMSEQ_PINS_LOWPWR:  decoded = FULL_FEATURE ? low_power_mode : sleep_power_mode;
         default:            decoded = sleep_power_mode;
      endcase
      // limited variant maps missing modes to sleep
   end

   // state
   pmseq_mode_e             mode_r, mode_nxt;
   pmseq_state_e            st_r, st_nxt;
   logic [PMSEQ_CNT_W-1:0]  cnt_r, cnt_nxt;
   logic                    done_r, done_nxt;
   logic                    mav_go_r, mav_go_nxt;
   logic [31:0]             mask_r, mask_nxt;
   logic [31:0]             ctrl_r, ctrl_nxt;
   logic [7:0]              lpth_r, lpth_nxt;
   logic [31:0]             retcfg_r, retcfg_nxt;
   logic [31:0]             rdata_r, rdata_nxt;
   logic                    rvalid_r, rvalid_nxt;
   logic [PMSEQ_MAV_W+PMSEQ_MAV_SHIFT-1:0] acc_r [3], acc_nxt [3];
   logic [PMSEQ_MAV_W-1:0]  mav_r [3], mav_nxt [3];
   logic [PMSEQ_MAV_SHIFT-1:0] scnt_r, scnt_nxt;
   logic [PMSEQ_RMS_W-1:0]  rmsi_r, rmsi_nxt, rmsv_r, rmsv_nxt;

   logic [PMSEQ_MAV_W-1:0]  samp [3];
   assign samp[0] = phase_sample_a;
   assign samp[1] = phase_sample_b;
   assign samp[2] = phase_sample_c;

   logic port_on, wr_ok, mav_run;
   assign port_on = mode_r inside {normal_power_mode, reduced_power_mode};
   assign wr_ok   = link.reg_wr && (mode_r == normal_power_mode);
   assign mav_run = mav_go_r && port_on;

   always_comb
   begin
      mode_nxt   = decoded;
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      done_nxt   = done_r;
      mav_go_nxt = mav_go_r;
      mask_nxt   = mask_r;
      ctrl_nxt   = ctrl_r;
      lpth_nxt   = lpth_r;
      retcfg_nxt = retcfg_r;
      // write-one-to-clear; a set in the same cycle wins below
      if (wr_ok && link.reg_addr == PMSEQ_REG_STATUS_B && link.reg_wdata[PMSEQ_DONE_BIT])
         done_nxt = 1'b0;
      if (wr_ok)
      begin
         if (link.reg_addr == PMSEQ_REG_IRQ_MASK)
            mask_nxt = link.reg_wdata;
         else if (link.reg_addr == PMSEQ_REG_CTRL)
            ctrl_nxt = link.reg_wdata;
         else if (link.reg_addr == PMSEQ_REG_LP_THRESH)
            lpth_nxt = link.reg_wdata[7:0];
         else if (link.reg_addr == PMSEQ_REG_RET_CONFIG)
            retcfg_nxt = link.reg_wdata;
      end
      if (decoded != mode_r)
      begin
         st_nxt     = PMSEQ_ST_IDLE;
         // from normal, mav keeps running with no start signal
         mav_go_nxt = (decoded == reduced_power_mode);
         if (decoded == reduced_power_mode && mode_r != normal_power_mode)
            done_nxt = 1'b1;
         if (decoded == normal_power_mode)
         begin
            // defaults; threshold and retained config left alone
            mask_nxt = PMSEQ_MASK_RST;
            ctrl_nxt = PMSEQ_CTRL_RST;
            done_nxt = 1'b0;
            st_nxt   = PMSEQ_ST_TRANS;
            cnt_nxt  = PMSEQ_CNT_W'(PMSEQ_TRANS_CYC);
         end
      end
      else
      begin
         case (st_r)
            PMSEQ_ST_TRANS:
            begin
               if (cnt_r <= PMSEQ_CNT_W'(1))
               begin
                  st_nxt     = PMSEQ_ST_DONE;
                  done_nxt   = 1'b1;
                  mav_go_nxt = 1'b1;
               end
               else
                  cnt_nxt = cnt_r - PMSEQ_CNT_W'(1);
            end
            PMSEQ_ST_DONE: st_nxt = PMSEQ_ST_IDLE;
            default:       st_nxt = st_r;
         endcase
      end
   end

   // mav: accumulate magnitudes over a window of samples
   always_comb
   begin
      scnt_nxt = mav_run ? scnt_r : '0;
      for (int i = 0; i < 3; i++)
      begin
         acc_nxt[i] = mav_run ? acc_r[i] : '0;
         mav_nxt[i] = mav_r[i];
      end
      if (mav_run && sample_strobe)
      begin
         scnt_nxt = scnt_r + PMSEQ_MAV_SHIFT'(1);
         for (int i = 0; i < 3; i++)
         begin
            acc_nxt[i] = acc_r[i] + (samp[i][PMSEQ_MAV_W-1] ?
               (PMSEQ_MAV_W+PMSEQ_MAV_SHIFT)'(~samp[i] + PMSEQ_MAV_W'(1)) :
               (PMSEQ_MAV_W+PMSEQ_MAV_SHIFT)'(samp[i]));
            if (scnt_r == '1)
            begin
               mav_nxt[i] = acc_nxt[i][PMSEQ_MAV_W+PMSEQ_MAV_SHIFT-1:PMSEQ_MAV_SHIFT];
               acc_nxt[i] = '0;
            end
         end
      end
      // rms updated only in normal mode
      rmsi_nxt = (mode_r == normal_power_mode) ? rms_current_in : rmsi_r;
      rmsv_nxt = (mode_r == normal_power_mode) ? rms_voltage_in : rmsv_r;
   end

   // read path: answer one cycle later, only while the port lives
   always_comb
   begin
      rvalid_nxt = link.reg_rd && port_on;
      rdata_nxt  = 32'h0000_0000;
      if (link.reg_rd && port_on)
      begin
         if (link.reg_addr == PMSEQ_REG_STATUS_B)
            rdata_nxt[PMSEQ_DONE_BIT] = done_r;
         else if (link.reg_addr == PMSEQ_REG_IRQ_MASK)
            rdata_nxt = mask_r;
         else if (link.reg_addr == PMSEQ_REG_CTRL)
            rdata_nxt = ctrl_r;
         else if (link.reg_addr == PMSEQ_REG_LP_THRESH)
            rdata_nxt = {24'h00_0000, lpth_r};
         else if (link.reg_addr == PMSEQ_REG_RET_CONFIG)
            rdata_nxt = retcfg_r;
         else if (link.reg_addr >= PMSEQ_REG_MAV_A && link.reg_addr <= PMSEQ_REG_MAV_C)
            rdata_nxt = {12'h000, mav_r[2'(link.reg_addr - PMSEQ_REG_MAV_A)]};
         else if (link.reg_addr == PMSEQ_REG_RMS_I)
            rdata_nxt = {8'h00, rmsi_r};
         else if (link.reg_addr == PMSEQ_REG_RMS_V)
            rdata_nxt = {8'h00, rmsv_r};
         else if (link.reg_addr == PMSEQ_REG_MODE)
            rdata_nxt = {30'h0000_0000, mode_r};
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_r   <= sleep_power_mode;
         st_r     <= PMSEQ_ST_IDLE;
         cnt_r    <= '0;
         done_r   <= 1'b0;
         mav_go_r <= 1'b0;
         mask_r   <= PMSEQ_MASK_RST;
         ctrl_r   <= PMSEQ_CTRL_RST;
         lpth_r   <= PMSEQ_LPTH_RST;
         retcfg_r <= PMSEQ_RETCFG_RST;
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
         scnt_r   <= '0;
         rmsi_r   <= '0;
         rmsv_r   <= '0;
         acc_r    <= '{default: '0};
         mav_r    <= '{default: '0};
      end
      else
      begin
         mode_r   <= mode_nxt;
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         done_r   <= done_nxt;
         mav_go_r <= mav_go_nxt;
         mask_r   <= mask_nxt;
         ctrl_r   <= ctrl_nxt;
         lpth_r   <= lpth_nxt;
         retcfg_r <= retcfg_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         scnt_r   <= scnt_nxt;
         rmsi_r   <= rmsi_nxt;
         rmsv_r   <= rmsv_nxt;
         acc_r    <= acc_nxt;
         mav_r    <= mav_nxt;
      end
   end

   // mask deliberately not consulted: flag is unmaskable
   assign link.event_irq_b_n = ~done_r;
   assign link.reg_rdata     = rdata_r;
   assign link.reg_rvalid    = rvalid_r;
   assign power_mode         = mode_r;
   assign ctrl_out           = ctrl_r;
endmodule : pmseq_device

// ---- core/pmseq_ctrl.sv ----
// controller end: drives mode pins and relays register traffic
`timescale 1ns/100ps
module pmseq_ctrl
   import pmseq_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // link to device
   pmseq_if.ctl             link,
   // software port
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic [31:0]      sw_rdata,
   // mode request and status
   input  wire logic [1:0]  mode_req,
   input  wire logic        pins_release,
   output logic             mav_ready,
   output logic             blocked
);
   logic [1:0] pins_r, pins_nxt;
   logic       rel_r, rel_nxt;
   logic       wait_r, wait_nxt;
   logic       irq_seen;

   assign irq_seen = ~link.event_irq_b_n;

   always_comb
   begin
      pins_nxt = mode_req;
      rel_nxt  = pins_release;
      wait_nxt = wait_r;
      // after leaving low/sleep for reduced, hold off until the irq
      if (mode_req == PMSEQ_PINS_REDUCED && pins_r != PMSEQ_PINS_REDUCED
          && pins_r != PMSEQ_PINS_NORMAL)
         wait_nxt = 1'b1;
      else if (irq_seen || mode_req != PMSEQ_PINS_REDUCED)
         wait_nxt = 1'b0;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pins_r <= PMSEQ_PINS_SLEEP;
         rel_r  <= 1'b1;
         wait_r <= 1'b0;
      end
      else
      begin
         pins_r <= pins_nxt;
         rel_r  <= rel_nxt;
         wait_r <= wait_nxt;
      end
   end

   logic allow;
   always_comb
   begin
      // reduced mode: only mav reads, no writes
      if (pins_r == PMSEQ_PINS_NORMAL)
         allow = 1'b1;
      else if (pins_r == PMSEQ_PINS_REDUCED)
         allow = !wait_r && sw_rd && (sw_addr == PMSEQ_REG_MAV_A || sw_addr == PMSEQ_REG_MAV_B
                           || sw_addr == PMSEQ_REG_MAV_C);
      else
         // reads pass; the device refuses them itself in low power and sleep
         allow = sw_rd;
   end

   assign link.mode_select_high_pin = pins_r[1];
   assign link.mode_select_low_pin  = pins_r[0];
   assign link.mode_high_oe         = ~rel_r;
   assign link.mode_low_oe          = ~rel_r;
   assign link.reg_addr             = sw_addr;
   assign link.reg_wdata            = sw_wdata;
   // acknowledge is a software write of bit 15 to status
   assign link.reg_wr               = sw_wr && allow;
   assign link.reg_rd               = sw_rd && allow;
   // answer stands only in the cycle after the read strobe
   assign sw_rdata                  = link.reg_rvalid ? link.reg_rdata : 32'h0000_0000;
   // mav values reach software raw; it keeps and applies the gains
   assign mav_ready                 = (pins_r == PMSEQ_PINS_REDUCED) && !wait_r;
   assign blocked                   = (sw_wr || sw_rd) && !allow;
endmodule : pmseq_ctrl

// ---- bench/pmseq_monitor.sv ----
// concurrent checks on the link between controller and device
`timescale 1ns/100ps
module pmseq_monitor
   import pmseq_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        arst_n,
   // link signals
   input wire logic        mode_high_level,
   input wire logic        mode_low_level,
   input wire logic        event_irq_b_n,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic        reg_rvalid
);
   logic [1:0] lvl;
   logic [1:0] lvl_prev_r;
   logic [1:0] lvl_prev_nxt;
   logic [7:0] stable_r;
   logic [7:0] stable_nxt;
   logic       clr_wr;

   assign lvl    = {mode_high_level, mode_low_level};
   assign clr_wr = reg_wr && (reg_addr == PMSEQ_REG_STATUS_B) && reg_wdata[PMSEQ_DONE_BIT];

   // cycles the resolved pin levels have held, saturating
   always_comb
   begin
      lvl_prev_nxt = lvl;
      stable_nxt   = 8'h00;
      if (lvl == lvl_prev_r)
      begin
         stable_nxt = (stable_r == 8'hFF) ? stable_r : stable_r + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lvl_prev_r <= 2'h3;
         stable_r   <= 8'h00;
      end
      else
      begin
         lvl_prev_r <= lvl_prev_nxt;
         stable_r   <= stable_nxt;
      end
   end

   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   // margins cover the pin synchroniser delay
   a_done_in_time: assert property ((lvl == 2'h1 && stable_r == 8'h08) |->
      ##[110:135] !event_irq_b_n) else $error("done flag late or missing");
   a_quiet_transition: assert property ((lvl == 2'h1 && stable_r >= 8'h08 &&
      stable_r <= 8'h6E) |-> event_irq_b_n) else $error("done raised during transition");
   a_irq_holds_low: assert property ((!event_irq_b_n && stable_r >= 8'h06 && !clr_wr)
      |=> !event_irq_b_n) else $error("irq released without clear");
   a_clear_releases: assert property ((lvl == 2'h1 && stable_r >= 8'h10 && clr_wr)
      |=> event_irq_b_n) else $error("clear write did not release irq");
   a_reduced_start: assert property ((lvl == 2'h0 && lvl_prev_r[1]) |->
      ##[2:8] !event_irq_b_n) else $error("no start signal on reduced entry");
   a_direct_reduced: assert property ((lvl == 2'h0 && lvl_prev_r == 2'h1 && event_irq_b_n)
      |=> event_irq_b_n [*8]) else $error("irq on direct reduced entry");
   a_port_dead: assert property ((lvl[1] && stable_r >= 8'h03 && reg_rd) |=> !reg_rvalid)
      else $error("read answered with port off");
   a_reduced_answers: assert property ((lvl == 2'h0 && stable_r >= 8'h06 && reg_rd)
      |=> reg_rvalid) else $error("read unanswered in reduced mode");
   a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("answer without read");
endmodule : pmseq_monitor

// ---- bench/tb_top.sv ----
// self-checking bench: controller and device joined over the link
`timescale 1ns/100ps
module tb_top
   import pmseq_pkg::*;
();
   logic                   core_clk = 1'b0;
   logic                   arst_n;
   logic [3:0]             sw_addr;
   logic [31:0]            sw_wdata;
   logic                   sw_wr;
   logic                   sw_rd;
   logic [31:0]            sw_rdata;
   logic [1:0]             mode_req;
   logic                   pins_release;
   logic                   mav_ready;
   logic [PMSEQ_MAV_W-1:0] smp_a, smp_b, smp_c;
   logic                   sample_strobe = 1'b0;
   logic                   blocked;
   int                     blk_cnt = 0;
   pmseq_mode_e            power_mode;
   pmseq_mode_e            lite_mode;
   logic [31:0]            ctrl_out;
   logic [31:0]            rd_val;
   int                     bad_count = 0;
   int                     tests_run = 0;

   pmseq_if lnk ();
   pmseq_if lnk2 ();

   always #4 core_clk = ~core_clk;
   always @(posedge core_clk)
      sample_strobe <= ~sample_strobe;
   // refused accesses seen at the controller
   always @(posedge core_clk)
      if (blocked === 1'b1)
         blk_cnt <= blk_cnt + 1;

   pmseq_device pmseq_device_i (.core_clk(core_clk), .arst_n(arst_n), .link(lnk),
      .phase_sample_a(smp_a), .phase_sample_b(smp_b), .phase_sample_c(smp_c),
      .sample_strobe(sample_strobe), .rms_current_in(24'hABCDEF),
      .rms_voltage_in(24'h123456), .power_mode(power_mode), .ctrl_out(ctrl_out));
   // two-mode variant on its own link, pins driven by the bench
   pmseq_device #(.FULL_FEATURE(1'b0)) pmseq_device_i2 (.core_clk(core_clk),
      .arst_n(arst_n), .link(lnk2), .phase_sample_a(smp_a), .phase_sample_b(smp_b),
      .phase_sample_c(smp_c), .sample_strobe(sample_strobe), .rms_current_in(24'hABCDEF),
      .rms_voltage_in(24'h123456), .power_mode(lite_mode), .ctrl_out());
   pmseq_ctrl pmseq_ctrl_i (.core_clk(core_clk), .arst_n(arst_n), .link(lnk),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .mode_req(mode_req), .pins_release(pins_release),
      .mav_ready(mav_ready), .blocked(blocked));
   pmseq_monitor pmseq_monitor_i (.core_clk(core_clk), .arst_n(arst_n),
      .mode_high_level(lnk.mode_high_level), .mode_low_level(lnk.mode_low_level),
      .event_irq_b_n(lnk.event_irq_b_n), .reg_addr(lnk.reg_addr),
      .reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
      .reg_rvalid(lnk.reg_rvalid));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge core_clk);
      sw_wr    <= 1'b0;
   endtask : wr

   // answer stands in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge core_clk);
      sw_rd   <= 1'b0;
      #1 d = sw_rdata;
   endtask : rd

   task automatic go(input logic [1:0] code, input logic rel, input pmseq_mode_e expm);
      int n;
      n = 0;
      @(posedge core_clk);
      mode_req     <= code;
      pins_release <= rel;
      do
      begin
         @(posedge core_clk);
         #1 n++;
      end
      while (power_mode !== expm && n < 20);
      check(power_mode, expm);
   endtask : go

   task automatic wait_irq();
      int n;
      n = 0;
      while (lnk.event_irq_b_n !== 1'b0 && n < 300)
      begin
         @(posedge core_clk);
         #1 n++;
      end
   endtask : wait_irq

   initial
   begin
      arst_n = 1'b0;
      {sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
      mode_req = PMSEQ_PINS_SLEEP;
      pins_release = 1'b1;
      smp_a = 20'h00064;
      smp_b = 20'hFFF38;
      smp_c = 20'h0012C;
      {lnk2.mode_high_oe, lnk2.mode_low_oe, lnk2.mode_select_high_pin} = 3'h7;
      lnk2.mode_select_low_pin = 1'b1;
      {lnk2.reg_addr, lnk2.reg_wdata, lnk2.reg_wr, lnk2.reg_rd} = '0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      #1 check(power_mode, sleep_power_mode);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge core_clk);
         {lnk2.mode_select_high_pin, lnk2.mode_select_low_pin} <= 2'(k);
         repeat (6) @(posedge core_clk);
         #1 check(lite_mode, (k == 1) ? normal_power_mode : sleep_power_mode);
      end
      go(PMSEQ_PINS_NORMAL, 1'b0, normal_power_mode);
      rd(PMSEQ_REG_STATUS_B, rd_val);
      check(rd_val & 32'h0000_8000, 32'h0);
      wait_irq();
      check(lnk.event_irq_b_n, 1'b0);
      rd(PMSEQ_REG_STATUS_B, rd_val);
      check(rd_val & 32'h0000_8000, 32'h0000_8000);
      wr(PMSEQ_REG_STATUS_B, 32'h0000_8000);
      rd(PMSEQ_REG_STATUS_B, rd_val);
      check(rd_val & 32'h0000_8000, 32'h0);
      check(lnk.event_irq_b_n, 1'b1);
      wr(PMSEQ_REG_IRQ_MASK, 32'h0000_8000);
      wr(PMSEQ_REG_CTRL, 32'h0000_00A5);
      wr(PMSEQ_REG_LP_THRESH, 32'h0000_005A);
      wr(PMSEQ_REG_RET_CONFIG, 32'h1234_5678);
      check(ctrl_out, 32'h0000_00A5);
      rd(PMSEQ_REG_RMS_I, rd_val);
      check(rd_val, 32'h00AB_CDEF);
      // averaging window of sixteen strobes must fill first
      repeat (40) @(posedge core_clk);
      for (int k = 0; k < 3; k++)
      begin
         rd(PMSEQ_REG_MAV_A + 4'(k), rd_val);
         check(rd_val, 32'h64 * (k + 1));
      end
      go(PMSEQ_PINS_REDUCED, 1'b0, reduced_power_mode);
      rd(PMSEQ_REG_MAV_A, rd_val);
      check(rd_val, 32'h0000_0064);
      wr(PMSEQ_REG_CTRL, 32'h0000_00FF);
      #1 check(ctrl_out, 32'h0000_00A5);
      check(blk_cnt, 1);
      go(PMSEQ_PINS_LOWPWR, 1'b0, low_power_mode);
      smp_b <= 20'hFFE70;
      rd(PMSEQ_REG_MAV_A, rd_val);
      check(rd_val, 32'h0);
      go(PMSEQ_PINS_REDUCED, 1'b0, reduced_power_mode);
      wait_irq();
      check(lnk.event_irq_b_n, 1'b0);
      check(mav_ready, 1'b0);
      @(posedge core_clk);
      #1 check(mav_ready, 1'b1);
      repeat (40) @(posedge core_clk);
      rd(PMSEQ_REG_MAV_B, rd_val);
      check(rd_val, 32'h0000_0190);
      go(PMSEQ_PINS_SLEEP, 1'b0, sleep_power_mode);
      go(PMSEQ_PINS_NORMAL, 1'b0, normal_power_mode);
      wait_irq();
      check(ctrl_out, PMSEQ_CTRL_RST);
      rd(PMSEQ_REG_IRQ_MASK, rd_val);
      check(rd_val, PMSEQ_MASK_RST);
      rd(PMSEQ_REG_LP_THRESH, rd_val);
      check(rd_val, 32'h0000_005A);
      rd(PMSEQ_REG_RET_CONFIG, rd_val);
      check(rd_val, 32'h1234_5678);
      wr(PMSEQ_REG_STATUS_B, 32'h0000_8000);
      go(PMSEQ_PINS_NORMAL, 1'b1, sleep_power_mode);
      check(power_mode, sleep_power_mode);
      tally_and_finish();
   end

   // whole run is under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      tally_and_finish();
   end
endmodule : tb_top
